// ==== rtl/gpfc_cfg.svh ====
`ifndef GPFC_CFG_SVH
`define GPFC_CFG_SVH

// ==========================================
// register indices (byte address = 4 * index)
`define GPFC_IDX_PIN_4_2 8'h3d
`define GPFC_IDX_PIN_4_3 8'h3e
`define GPFC_IDX_PIN_5_0 8'h3f
`define GPFC_IDX_PIN_5_1 8'h40
`define GPFC_IDX_PIN_5_2 8'h41
`define GPFC_IDX_PIN_5_3 8'h42
`define GPFC_IDX_PIN_5_4 8'h43
`define GPFC_IDX_DATA 8'h50
`define GPFC_IDX_IRQ_STATUS 8'h51
`define GPFC_IDX_IRQ_MASK 8'h52

// ==========================================
// field positions
`define GPFC_BIT_DIR 0
`define GPFC_BIT_POL 1
`define GPFC_BIT_ALT 2
`define GPFC_FSEL_LO 2
`define GPFC_FSEL_HI 3
`define GPFC_BIT_ODRAIN 7

// ==========================================
// reset values and status bits
`define GPFC_RST_INPUT 8'h01
`define GPFC_RST_PIN_5_3 8'h00
`define GPFC_NUM_PINS 7
`define GPFC_NUM_EVENTS 2
`define GPFC_EV_EDGE 0
`define GPFC_EV_LOCK_PIN 1

`endif

// ==== rtl/gpfc_pkg.sv ====
package gpfc_pkg;

   typedef logic [31:0] gpfc_word_t;
   typedef logic [7:0] gpfc_cfg_t;

   // two-bit alternate function select codes
   typedef enum logic [1:0] {
      GPFC_FN_GPIO = 2'b00,
      GPFC_FN_ALT = 2'b01,
      GPFC_FN_RSVD = 2'b10,
      GPFC_FN_EDGE = 2'b11
   } gpfc_fsel_t;

endpackage : gpfc_pkg

// ==== rtl/gpfc_sync.sv ====
// ==========================================
// three-stage pad synchroniser with agreement filter
module gpfc_sync #(
   parameter int WIDTH = 7
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] level_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level_q <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               level_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign level_out = level_q;

endmodule : gpfc_sync

// ==== rtl/gpfc_top.sv ====
// Function
// [R01] Bit 0 of each pin register makes the pin an input when one and an output when zero.
// [R02] Bit 1 of each pin register inverts the value between pad and logic when one.
// [R03] Bit 7 of each pin register selects open-drain drive when one and push-pull when zero.
// [R04] On pin 4.2 bit 2 routes the power event output to the pad, else plain GPIO; bits 6:3 reserved.
// [R05] The power event output, as a non-inverted output, is driven active low in either drive type.
// [R06] On pin 4.3 bits 3:2 give 11 edge interrupt 3, 10 reserved, 01 disable-lock control, 00 GPIO.
// [R07] In disable-lock control pin 4.3 is a non-inverted input regardless of bits 0 and 1.
// [R08] Once the pin 4.3 select holds 01 software writes to that field are ignored.
// [R09] The pin 4.3 select is cleared by standby POR, main POR or hard reset, which alone free the lock.
// [R10] In disable-lock control the device-disable register is read-only while pin 4.3 is high.
// [R11] On pin 5.0 select 01 gives the serial port two ring indicator input, 00 GPIO, others reserved.
// [R12] At select 01 pins 5.1 to 5.4 carry carrier detect, receive data, transmit data and set-ready.
// [R13] In registers with a two-bit select, bits 6:4 are reserved.
// [R14] Pin 5.3 register resets to 0x00 on every reset, giving a non-inverted push-pull output.
// [R15] The other pin registers reset to 0x01 on standby POR, giving non-inverted GPIO inputs.
// [R16] Reserved bits read back as written and reserved select codes behave as plain GPIO.
`include "gpfc_cfg.svh"

module gpfc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire gpfc_pkg::gpfc_word_t hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output gpfc_pkg::gpfc_word_t hrdata,
   input wire logic main_reset_req,
   input wire logic [6:0] pad_in,
   output logic [6:0] pad_out,
   output logic [6:0] pad_oe,
   input wire logic power_event_out_n,
   input wire logic uart_b_transmit_line,
   output logic uart_b_ring_indicator_n,
   output logic uart_b_carrier_detect_n,
   output logic uart_b_receive_line,
   output logic uart_b_set_ready_n,
   output logic device_disable_writable,
   output logic device_disable_lock_control,
   output logic edge_int3_pulse,
   output logic irq
);
   import gpfc_pkg::*;

   // ==========================================
   // pin slots, in register order
   localparam int P42 = 0;
   localparam int P43 = 1;
   localparam int P50 = 2;
   localparam int P51 = 3;
   localparam int P52 = 4;
   localparam int P53 = 5;
   localparam int P54 = 6;
   localparam int NP = `GPFC_NUM_PINS;
   localparam int NE = `GPFC_NUM_EVENTS;

   gpfc_cfg_t cfg_q [NP];
   logic [NP-1:0] data_q;
   logic [NE-1:0] status_q;
   logic [NE-1:0] mask_q;
   logic [NP-1:0] pad_lvl;
   logic [2:0] mrst_q;
   logic main_rst;
   logic lvl43_prev_q;

   // ==========================================
   // functions
   function automatic gpfc_fsel_t fsel(input gpfc_cfg_t c);
      return gpfc_fsel_t'(c[`GPFC_FSEL_HI:`GPFC_FSEL_LO]);
   endfunction : fsel

   // returns {oe, out} for a pad from its config and logic value
   function automatic logic [1:0] pad_drive(input gpfc_cfg_t c, input logic v);
      logic val;
      val = v ^ c[`GPFC_BIT_POL]; // R02
      if (c[`GPFC_BIT_DIR]) begin
         return 2'b00; // R01
      end else if (c[`GPFC_BIT_ODRAIN]) begin
         return {~val, 1'b0}; // R03
      end else begin
         return {1'b1, val}; // R03
      end
   endfunction : pad_drive

   // byte address to register index, 8'hff when not word aligned in range
   function automatic logic [7:0] word_index(input logic [31:0] a);
      if (a[1:0] != 2'b00 || a[31:10] != '0) begin
         return 8'hff;
      end
      return a[9:2];
   endfunction : word_index

   // ==========================================
   // pad and reset synchronisers
   gpfc_sync #(
      .WIDTH(NP)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(pad_in),
      .level_out(pad_lvl)
   );

   // main power POR / hard reset request from the board, three-stage filtered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mrst_q <= 3'b000;
      end else begin
         mrst_q <= {mrst_q[1:0], main_reset_req};
      end
   end

   logic main_rst_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         main_rst_q <= 1'b0;
      end else if (mrst_q[1] == mrst_q[2]) begin
         main_rst_q <= mrst_q[2];
      end
   end
   assign main_rst = main_rst_q;

   // ==========================================
   // AHB-Lite slave: zero wait states, always OKAY
   logic ph_valid_q;
   logic ph_write_q;
   logic [7:0] ph_index_q;
   logic addr_ok;

   assign addr_ok = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_q <= 1'b0;
         ph_write_q <= 1'b0;
         ph_index_q <= 8'h00;
      end else begin
         ph_valid_q <= addr_ok;
         ph_write_q <= hwrite;
         ph_index_q <= word_index(haddr);
      end
   end

   logic wr_en;
   assign wr_en = ph_valid_q && ph_write_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ==========================================
   // pin configuration registers
   logic lock43;
   assign lock43 = (fsel(cfg_q[P43]) == GPFC_FN_ALT);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NP; i++) begin
            cfg_q[i] <= `GPFC_RST_INPUT; // R15
         end
         cfg_q[P53] <= `GPFC_RST_PIN_5_3; // R14
      end else begin
         for (int i = 0; i < NP; i++) begin
            if (wr_en && ph_index_q == `GPFC_IDX_PIN_4_2 + 8'(i)) begin
               cfg_q[i] <= hwdata[7:0]; // R16
               if (i == P43 && lock43) begin
                  cfg_q[i][`GPFC_FSEL_HI:`GPFC_FSEL_LO] <= GPFC_FN_ALT; // R08
               end
            end
         end
         if (main_rst) begin
            cfg_q[P43][`GPFC_FSEL_HI:`GPFC_FSEL_LO] <= GPFC_FN_GPIO; // R09
            cfg_q[P53] <= `GPFC_RST_PIN_5_3; // R14
         end
      end
   end

   // output data for pins in plain GPIO output mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_q <= '0;
      end else if (wr_en && ph_index_q == `GPFC_IDX_DATA) begin
         data_q <= hwdata[NP-1:0];
      end
   end

   // ==========================================
   // effective per-pin behaviour
   gpfc_cfg_t eff [NP];
   logic [NP-1:0] src;
   logic [NP-1:0] in_val;

   always_comb begin
      for (int i = 0; i < NP; i++) begin
         eff[i] = cfg_q[i];
         src[i] = data_q[i];
      end
      if (cfg_q[P42][`GPFC_BIT_ALT]) begin
         src[P42] = power_event_out_n; // R04 R05
      end
      if (lock43) begin
         eff[P43][`GPFC_BIT_DIR] = 1'b1; // R07
         eff[P43][`GPFC_BIT_POL] = 1'b0; // R07
      end
      if (fsel(cfg_q[P53]) == GPFC_FN_ALT) begin
         src[P53] = uart_b_transmit_line; // R12
      end
      for (int i = 0; i < NP; i++) begin
         in_val[i] = pad_lvl[i] ^ eff[i][`GPFC_BIT_POL]; // R02
      end
   end

   // pad drivers; reserved codes fall through to GPIO
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pad_out <= '0;
         pad_oe <= '0;
      end else begin
         for (int i = 0; i < NP; i++) begin
            {pad_oe[i], pad_out[i]} <= pad_drive(eff[i], src[i]); // R01 R03 R16
         end
      end
   end

   // ==========================================
   // serial port two inputs; idle level when not routed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         uart_b_ring_indicator_n <= 1'b1;
         uart_b_carrier_detect_n <= 1'b1;
         uart_b_receive_line <= 1'b1;
         uart_b_set_ready_n <= 1'b1;
      end else begin
         uart_b_ring_indicator_n <= (fsel(cfg_q[P50]) == GPFC_FN_ALT) ? in_val[P50] : 1'b1; // R11
         uart_b_carrier_detect_n <= (fsel(cfg_q[P51]) == GPFC_FN_ALT) ? in_val[P51] : 1'b1; // R12 R13
         uart_b_receive_line <= (fsel(cfg_q[P52]) == GPFC_FN_ALT) ? in_val[P52] : 1'b1; // R12
         uart_b_set_ready_n <= (fsel(cfg_q[P54]) == GPFC_FN_ALT) ? in_val[P54] : 1'b1; // R12
      end
   end

   // ==========================================
   // device-disable lock and edge interrupt 3
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         device_disable_lock_control <= 1'b0;
         device_disable_writable <= 1'b1;
      end else begin
         device_disable_lock_control <= lock43; // R06
         device_disable_writable <= lock43 ? ~pad_lvl[P43] : 1'b1; // R10
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lvl43_prev_q <= 1'b0;
      end else begin
         lvl43_prev_q <= pad_lvl[P43];
      end
   end

   logic edge43;
   logic [NE-1:0] ev;
   assign edge43 = (pad_lvl[P43] != lvl43_prev_q);
   assign ev[`GPFC_EV_EDGE] = edge43 && (fsel(cfg_q[P43]) == GPFC_FN_EDGE); // R06
   assign ev[`GPFC_EV_LOCK_PIN] = edge43 && lock43;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         edge_int3_pulse <= 1'b0;
      end else begin
         edge_int3_pulse <= ev[`GPFC_EV_EDGE];
      end
   end

   // ==========================================
   // interrupt status (write one to clear; a new event wins) and mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q <= '0;
      end else begin
         for (int i = 0; i < NE; i++) begin
            if (ev[i]) begin
               status_q[i] <= 1'b1;
            end else if (wr_en && ph_index_q == `GPFC_IDX_IRQ_STATUS && hwdata[i]) begin
               status_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= '0;
      end else if (wr_en && ph_index_q == `GPFC_IDX_IRQ_MASK) begin
         mask_q <= hwdata[NE-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end

   // ==========================================
   // read data, captured at the address phase; the master idles during
   // every data phase, so a write always lands before the next read
   gpfc_word_t rd_d;
   logic [7:0] rd_idx;

   always_comb begin
      rd_idx = word_index(haddr);
      rd_d = '0;
      for (int i = 0; i < NP; i++) begin
         if (rd_idx == `GPFC_IDX_PIN_4_2 + 8'(i)) begin
            rd_d = {24'h000000, cfg_q[i]};
         end
      end
      if (rd_idx == `GPFC_IDX_DATA) begin
         rd_d = {25'h0000000, in_val};
      end else if (rd_idx == `GPFC_IDX_IRQ_STATUS) begin
         rd_d = {30'h00000000, status_q};
      end else if (rd_idx == `GPFC_IDX_IRQ_MASK) begin
         rd_d = {30'h00000000, mask_q};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (addr_ok && !hwrite) begin
         hrdata <= rd_d;
      end
   end

endmodule : gpfc_top

// ==== bench/gpfc_board.sv ====
// ==========================================
// board side: pull-up on every pad, optional external drive
module gpfc_board (
   input wire logic [6:0] pad_out,
   input wire logic [6:0] pad_oe,
   input wire logic [6:0] ext_en,
   input wire logic [6:0] ext_val,
   output logic [6:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // released open-drain lines float up, never hold their last value
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule : gpfc_board

// ==== bench/gpfc_top_sva.sv ====
// ==========================================
// port checker
module gpfc_top_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic main_reset_req,
   input wire logic [6:0] pad_oe,
   input wire logic device_disable_writable,
   input wire logic device_disable_lock_control,
   input wire logic edge_int3_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
   a_lock_input: assert property (device_disable_lock_control && $past(device_disable_lock_control) |-> !pad_oe[1])
      else $error("locked pin driven");
   a_lock_writable: assert property (!device_disable_lock_control && !$past(device_disable_lock_control)
      |-> device_disable_writable) else $error("writable low without lock");
   a_lock_sticky: assert property ((!main_reset_req) [*8] ##0 device_disable_lock_control
      |=> device_disable_lock_control) else $error("lock released");
   a_main_clear: assert property (main_reset_req [*8] |-> !device_disable_lock_control)
      else $error("lock kept in main reset");
   a_main_out: assert property (main_reset_req [*8] |-> pad_oe[5]) else $error("pin 5.3 not output");
   a_reset_pads: assert property ($rose(hresetn) |=> pad_oe == 7'h20) else $error("pad reset state");
   a_pulse_single: assert property (edge_int3_pulse |=> !edge_int3_pulse) else $error("edge pulse long");
endmodule : gpfc_top_sva

bind gpfc_top gpfc_top_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .main_reset_req(main_reset_req), .pad_oe(pad_oe), .device_disable_writable(device_disable_writable),
   .device_disable_lock_control(device_disable_lock_control), .edge_int3_pulse(edge_int3_pulse));

// ==== bench/testbench.sv ====
`include "gpfc_cfg.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import gpfc_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, main_reset_req = 0, pen = 1, txd = 1, rd_ph = 0;
   logic [31:0] haddr = 0, mk, r;
   logic [1:0] htrans = 0;
   gpfc_word_t hwdata = '0, hrdata;
   logic hreadyout, hresp, ri, dcd, rxd, dsr, wen, lock, ep, irq, v;
   logic [6:0] pad_in, pad_out, pad_oe, ext_en = 0, ext_val = 0;
   logic [7:0] cf [6] = '{8'h00, 8'h02, 8'h80, 8'h82, 8'h01, 8'h08};
   logic [31:0] q_exp [$], q_msk [$];
   int num_errors = 0, compares = 0, n;
   gpfc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .main_reset_req(main_reset_req), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .power_event_out_n(pen), .uart_b_transmit_line(txd), .uart_b_ring_indicator_n(ri),
      .uart_b_carrier_detect_n(dcd), .uart_b_receive_line(rxd), .uart_b_set_ready_n(dsr),
      .device_disable_writable(wen), .device_disable_lock_control(lock), .edge_int3_pulse(ep), .irq(irq));
   gpfc_board i_board (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
   initial begin
      forever #5 hclk = ~hclk;
   end
   task automatic end_sim;
      if (num_errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // a read notes its expectation; the monitor compares in the data phase
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [31:0] m);
      @(posedge hclk);
      hsel <= 1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      if (!w) begin
         q_exp.push_back(d);
         q_msk.push_back(m);
      end
      hsel <= 0;
      htrans <= 0;
      hwdata <= w ? d : 32'h0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask : xfer
   task automatic tick(input int k);
      repeat (k) @(posedge hclk);
      #1;
   endtask : tick
   task automatic rst_chk;
      @(posedge hclk);
      hresetn <= 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1;
      for (int i = 8'h3d; i <= 8'h43; i++) xfer(0, i, (i == 8'h42) ? 0 : 1, '1);
   endtask : rst_chk
   always @(posedge hclk) begin
      if (rd_ph && hreadyout === 1'b1) begin
         mk = q_msk.pop_front();
         chk(hrdata & mk, q_exp.pop_front() & mk);
      end
      rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
   end
   initial begin
      #100000;
      num_errors++;
      end_sim();
   end
   initial begin
      void'($urandom(85319));
      rst_chk();
      xfer(0, 8'h60, 0, '1);
      for (int i = 8'h3f; i <= 8'h43; i++) begin
         r = $urandom & 32'hff;
         xfer(1, i, r, 0);
         xfer(0, i, r, '1);
      end
      // ==========================================
      // drive table on pin 5.1
      for (int k = 0; k < 6; k++) begin
         r = $urandom;
         xfer(1, `GPFC_IDX_DATA, r, 0);
         xfer(1, `GPFC_IDX_PIN_5_1, cf[k], 0);
         tick(2);
         v = r[3] ^ cf[k][1];
         chk({pad_oe[3] & pad_out[3], pad_oe[3]}, cf[k][0] ? 2'b00 : cf[k][7] ? {1'b0, !v} : {v, 1'b1});
      end
      xfer(1, `GPFC_IDX_PIN_5_1, 8'h03, 0);
      ext_en[3] <= 1;
      ext_val[3] <= r[0];
      tick(6);
      xfer(0, `GPFC_IDX_DATA, {!r[0], 3'b000}, 32'h8);
      for (int j = 0; j < 4; j++) begin
         xfer(1, `GPFC_IDX_PIN_4_2, j[1] ? 8'h84 : 8'h04, 0);
         pen <= j[0];
         tick(2);
         chk({pad_oe[0] & pad_out[0], pad_oe[0]}, j[1] ? {1'b0, !j[0]} : {j[0], 1'b1});
      end
      // ==========================================
      // serial port two routing
      for (int i = 8'h3f; i <= 8'h43; i++) xfer(1, i, (i == 8'h42) ? 8'h04 : 8'h05, 0);
      // low last, so the later switch back to plain GPIO must raise ri
      for (int j = 1; j >= 0; j--) begin
         @(posedge hclk);
         ext_en <= 7'h5c;
         ext_val <= {7{j[0]}};
         txd <= !j[0];
         tick(6);
         chk({ri, dcd, rxd, dsr, pad_out[5]}, {{4{j[0]}}, !j[0]});
      end
      xfer(1, `GPFC_IDX_PIN_5_0, 8'h01, 0);
      tick(2);
      chk(ri, 1);
      // ==========================================
      // edge interrupt, mask, clear
      xfer(1, `GPFC_IDX_PIN_4_3, 8'h0d, 0);
      xfer(1, `GPFC_IDX_IRQ_STATUS, 3, 0);
      ext_en[1] <= 1;
      ext_val[1] <= 0;
      n = 0;
      tick(1);
      while (ep !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk(ep, 1);
      tick(2);
      chk(irq, 0);
      xfer(0, `GPFC_IDX_IRQ_STATUS, 1, 1);
      xfer(1, `GPFC_IDX_IRQ_MASK, 1, 0);
      tick(2);
      chk(irq, 1);
      xfer(1, `GPFC_IDX_IRQ_STATUS, 1, 0);
      tick(2);
      chk(irq, 0);
      // ==========================================
      // disable lock
      xfer(1, `GPFC_IDX_PIN_4_3, 8'h06, 0);
      ext_val[1] <= 1;
      tick(6);
      chk({lock, pad_oe[1], wen}, 3'b100);
      @(posedge hclk);
      ext_val[1] <= 0;
      tick(6);
      chk(wen, 1);
      xfer(1, `GPFC_IDX_PIN_4_3, 8'h00, 0);
      xfer(0, `GPFC_IDX_PIN_4_3, 8'h04, '1);
      xfer(0, `GPFC_IDX_IRQ_STATUS, 2, 2);
      @(posedge hclk);
      main_reset_req <= 1;
      repeat (7) @(posedge hclk);
      xfer(1, `GPFC_IDX_PIN_5_3, 8'hff, 0);
      main_reset_req <= 0;
      tick(6);
      chk(lock, 0);
      xfer(0, `GPFC_IDX_PIN_4_3, 8'h00, '1);
      xfer(0, `GPFC_IDX_PIN_5_3, 8'h00, '1);
      rst_chk();
      tick(2);
      end_sim();
   end
endmodule : testbench
